// File: verif/link_partner.sv
// behavioural model of the computer link unit and checkout computer
`timescale 1ns/1ps
module link_partner (
    input wire logic mclk, // clock
    input wire logic rst, // async reset
    input wire logic slow, // answer data requests late
    input wire console_pkg::test_req_t test_req, // request from console
    input wire console_pkg::command_t command, // command from console
    input wire logic [1:0] dreq_valid, // data request strobes
    input wire logic [1:0][11:0] dreq_number, // data request numbers
    output logic [17:0] running_test, // test being run
    output logic [17:0] next_test, // test queued
    output logic cond_cleared, // condition released pulse
    output logic [1:0] dreq_answer_valid, // answer strobes
    output logic [1:0][31:0] dreq_answer, // answer words
    output logic [23:0] link_ch5_data // channel five word
);
    logic [1:0][2:0] wait_q;
    logic [1:0][31:0] held_q;
    // answer lines are not held once the strobe drops
    assign dreq_answer[0] = dreq_answer_valid[0] ? held_q[0] : ~held_q[0];
    assign dreq_answer[1] = dreq_answer_valid[1] ? held_q[1] : ~held_q[1];
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            running_test <= 18'h00000;
            next_test <= 18'h00000;
            cond_cleared <= 1'b0;
            link_ch5_data <= 24'h000000;
            dreq_answer_valid <= 2'h0;
            wait_q <= '0;
            held_q <= '0;
        end else begin
            cond_cleared <= (command == console_pkg::cmd_resume);
            if (test_req.valid) begin
                next_test <= test_req.test_no;
                running_test <= next_test;
                link_ch5_data <= {6'h15, test_req.test_no};
            end
            for (int i = 0; i < 2; i++) begin
                dreq_answer_valid[i] <= 1'b0;
                if (dreq_valid[i]) begin
                    held_q[i] <= {20'ha5a5a, dreq_number[i]};
                    wait_q[i] <= slow ? 3'h5 : 3'h1;
                end else if (wait_q[i] != 3'h0) begin
                    wait_q[i] <= wait_q[i] - 3'h1;
                    dreq_answer_valid[i] <= (wait_q[i] == 3'h1);
                end
            end
        end
    end
endmodule : link_partner

// File: verif/tb.sv
// self-checking testbench for the operator console command logic
`timescale 1ns/1ps
module tb;
    logic mclk, rst, enter_key, kbd_clear_key, cond_stop_en, cond_hold_en, single_step_en;
    logic auto_hold, auto_stop, auto_estop, sim_int_event, sim_int_done, sim_on, sim_enter_key;
    logic slow, cond_cleared, step_grant, cond_stop_out, cond_hold_out, point_stored_ind;
    logic single_step_ind, sim_int_ind, sim_word_valid, sim_on_ind;
    logic [7:0] digit_key;
    logic [5:0] ck; // hold stop estop resume clear store
    logic [2:0] stn_req, stn_enable, stn_fwd_key, stn_wait_key, stn_pending_ind, sim_channel;
    logic [2:0][17:0] stn_test_no, stn_readout;
    console_pkg::station_status_t [2:0] stn_status_in, stn_status_ind;
    logic [23:0] sim_switches, link_ch5_data, sim_word, ch5_lamps;
    logic [1:0][11:0] dreq_select, dreq_number;
    logic [1:0] dreq_initiate, dreq_continuous, dreq_answer_valid, dreq_valid;
    logic [1:0][31:0] dreq_answer, data_value_disp;
    logic [17:0] running_test, next_test, kbd_readout, running_readout, next_readout;
    console_pkg::test_req_t test_req;
    console_pkg::command_t command;
    console_pkg::cond_ind_t hold_ind, stop_ind, estop_ind;
    int num_errors = 0;
    int check_count = 0;

    operator_logic_unit #(.REPEAT_CYC(4)) uut (.mclk, .rst, .digit_key, .enter_key,
        .kbd_clear_key, .hold_key(ck[0]), .stop_key(ck[1]), .estop_key(ck[2]),
        .resume_key(ck[3]), .clear_key(ck[4]), .store_key(ck[5]), .cond_stop_en,
        .cond_hold_en, .single_step_en, .running_test, .next_test, .auto_hold, .auto_stop,
        .auto_estop, .cond_cleared, .sim_int_event, .sim_int_done, .stn_test_no, .stn_req,
        .stn_status_in, .stn_enable, .stn_fwd_key, .stn_wait_key, .sim_on, .sim_switches,
        .sim_enter_key, .link_ch5_data, .dreq_select, .dreq_initiate, .dreq_continuous,
        .dreq_answer_valid, .dreq_answer, .kbd_readout, .running_readout, .next_readout,
        .test_req, .command, .step_grant, .cond_stop_out, .cond_hold_out, .hold_ind, .stop_ind,
        .estop_ind, .point_stored_ind, .single_step_ind, .sim_int_ind, .stn_readout,
        .stn_status_ind, .stn_pending_ind, .sim_word_valid, .sim_word, .sim_channel,
        .ch5_lamps, .sim_on_ind, .dreq_valid, .dreq_number, .data_value_disp);

    link_partner partner (.mclk, .rst, .slow, .test_req, .command, .dreq_valid, .dreq_number,
        .running_test, .next_test, .cond_cleared, .dreq_answer_valid, .dreq_answer,
        .link_ch5_data);

    task automatic tick(input int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic press(input logic [5:0] keys);
        // idle cycle first, so back-to-back presses never rewrite ck in one time step
        tick();
        ck = keys;
        tick();
        ck = 6'h00;
    endtask : press

    task automatic t_keyboard;
        for (int d = 1; d < 8; d++) begin
            digit_key = 8'h01 << d;
            tick();
        end
        digit_key = 8'h00;
        chk(kbd_readout, 18'h13977, "six newest digits");
        enter_key = 1'b1;
        tick();
        enter_key = 1'b0;
        chk(test_req, {3'h0, 18'h13977, 1'b1}, "keyboard entry");
        kbd_clear_key = 1'b1;
        tick();
        kbd_clear_key = 1'b0;
        chk(kbd_readout, 18'h00000, "keyboard clear");
        digit_key = 8'h20;
        tick();
        digit_key = 8'h00;
        enter_key = 1'b1;
        tick();
        enter_key = 1'b0;
        tick(3);
        chk({running_readout, next_readout}, {18'h13977, 18'h00005}, "readouts");
    endtask : t_keyboard

    task automatic t_commands;
        console_pkg::command_t exp_cmd [6];
        exp_cmd = '{console_pkg::cmd_hold, console_pkg::cmd_stop, console_pkg::cmd_estop,
            console_pkg::cmd_resume, console_pkg::cmd_clear, console_pkg::cmd_store};
        for (int i = 0; i < 6; i++) begin
            press(6'h01 << i);
            chk(command, exp_cmd[i], "command code");
        end
        chk(point_stored_ind, 1'b1, "point stored");
        press(6'h20);
        chk({command, point_stored_ind}, {console_pkg::cmd_return, 1'b0}, "return");
        press(6'h05);
        chk(command, console_pkg::cmd_estop, "estop beats hold");
        press(6'h12);
        chk(command, console_pkg::cmd_clear, "clear beats stop");
        press(6'h10);
        tick();
    endtask : t_commands

    task automatic t_indicators;
        press(6'h01);
        chk(hold_ind, 2'b11, "operator hold");
        auto_stop = 1'b1;
        auto_estop = 1'b1;
        tick();
        {auto_stop, auto_estop} = 2'b00;
        chk({stop_ind, estop_ind}, 4'ha, "automatic stop");
        press(6'h08);
        tick(3);
        chk({hold_ind, stop_ind, estop_ind}, 6'h00, "resumed");
        auto_hold = 1'b1;
        tick();
        auto_hold = 1'b0;
        chk(hold_ind, 2'b10, "automatic hold");
        press(6'h10);
        tick();
        sim_int_event = 1'b1;
        tick();
        sim_int_event = 1'b0;
        chk({sim_int_ind, hold_ind}, 3'h4, "interrupt lamp");
        sim_int_done = 1'b1;
        tick();
        sim_int_done = 1'b0;
        chk({sim_int_ind, hold_ind}, 3'h6, "lamp stays, hold shown");
        press(6'h10);
        tick();
        chk({sim_int_ind, hold_ind}, 3'h0, "cleared");
    endtask : t_indicators

    task automatic t_modes;
        {cond_stop_en, cond_hold_en, single_step_en} = 3'b101;
        tick();
        chk({cond_stop_out, cond_hold_out, single_step_ind}, 3'b101, "modes");
        {cond_stop_en, cond_hold_en} = 2'b01;
        press(6'h08);
        chk({cond_stop_out, cond_hold_out, step_grant}, 3'b011, "step");
        tick();
        chk(step_grant, 1'b0, "one step only");
        single_step_en = 1'b0;
        press(6'h08);
        chk(step_grant, 1'b0, "no step outside mode");
        tick(3);
    endtask : t_modes

    task automatic t_stations;
        stn_test_no = {18'h00111, 18'h00222, 18'h00333};
        stn_status_in = 12'h124;
        stn_enable = 3'b010;
        stn_req = 3'b010;
        tick();
        stn_req = 3'b000;
        chk({stn_pending_ind, stn_readout[1]}, {3'b010, 18'h00222}, "pending");
        chk(stn_status_ind, 12'h124, "station lamps");
        tick();
        chk(test_req, {3'h2, 18'h00222, 1'b1}, "direct entry");
        stn_enable = 3'b000;
        stn_wait_key = 3'b001;
        stn_req = 3'b001;
        tick();
        stn_req = 3'b000;
        tick(3);
        chk(stn_pending_ind, 3'b001, "deferred");
        stn_wait_key = 3'b000;
        stn_fwd_key = 3'b001;
        tick();
        stn_fwd_key = 3'b000;
        for (int n = 0; n < 4 && test_req.valid !== 1'b1; n++) tick();
        chk(test_req, {3'h1, 18'h00333, 1'b1}, "forwarded");
        stn_enable = 3'b100;
        stn_req = 3'b100;
        tick();
        stn_req = 3'b000;
        enter_key = 1'b1;
        tick();
        enter_key = 1'b0;
        chk(test_req, {3'h0, 18'h00005, 1'b1}, "master first");
        tick();
        chk(test_req, {3'h3, 18'h00111, 1'b1}, "station after");
        stn_enable = 3'b000;
    endtask : t_stations

    task automatic t_sim;
        sim_switches = 24'h800001;
        sim_enter_key = 1'b1;
        tick();
        sim_enter_key = 1'b0;
        chk({sim_word_valid, ch5_lamps, sim_on_ind}, 26'h0, "panel off");
        sim_on = 1'b1;
        tick();
        chk({ch5_lamps, sim_on_ind}, {6'h15, 18'h00111, 1'b1}, "lamps");
        sim_enter_key = 1'b1;
        tick();
        sim_enter_key = 1'b0;
        chk({sim_word_valid, sim_channel, sim_word}, {4'he, 24'h800001}, "word");
    endtask : t_sim

    task automatic t_dreq;
        int n;
        dreq_select = {12'h7ff, 12'h123};
        dreq_continuous = 2'b01;
        dreq_initiate = 2'b01;
        tick();
        dreq_initiate = 2'b00;
        chk({dreq_valid, dreq_number[0]}, {2'b01, 12'h123}, "request");
        tick(3);
        chk(dreq_valid, 2'b00, "no early repeat");
        tick();
        chk(dreq_valid, 2'b01, "repeat");
        dreq_continuous = 2'b00;
        n = 0;
        repeat (8) begin
            tick();
            n += dreq_valid[0];
        end
        chk(n, 0, "repeat stops");
        chk(data_value_disp[0], {20'ha5a5a, 12'h123}, "display");
        slow = 1'b1;
        dreq_initiate = 2'b10;
        tick();
        dreq_initiate = 2'b00;
        chk({dreq_valid, dreq_number[1]}, {2'b10, 12'h7ff}, "second set");
        tick(3);
        chk(data_value_disp[1], 32'h0, "not yet answered");
        tick(6);
        chk(data_value_disp[1], {20'ha5a5a, 12'h7ff}, "late answer");
    endtask : t_dreq

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #100us;
        num_errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        {enter_key, kbd_clear_key, cond_stop_en, cond_hold_en, single_step_en} = '0;
        {auto_hold, auto_stop, auto_estop, sim_int_event, sim_int_done, sim_on} = '0;
        {sim_enter_key, slow, digit_key, ck, stn_req, stn_enable, stn_fwd_key} = '0;
        {stn_wait_key, stn_test_no, stn_status_in, sim_switches} = '0;
        {dreq_select, dreq_initiate, dreq_continuous} = '0;
        tick(20);
        rst = 1'b0;
        tick();
        t_keyboard();
        t_commands();
        t_indicators();
        t_modes();
        t_stations();
        t_sim();
        t_dreq();
        print_verdict();
    end
endmodule : tb

// File: verilog/console_defs.svh
// constants for the operator console command logic
`ifndef CONSOLE_DEFS_SVH
`define CONSOLE_DEFS_SVH
`define DIGITS_KEY 6
`define DIGITS_REQ 4
`define SIM_WORD_BITS 24
`define SIM_IN_CHANNEL 3'h6
`define SIM_OUT_CHANNEL 3'h5
`define NUM_STATIONS 3
`define CONT_REPEAT_NS 1000
`define CLK_PERIOD_NS 10
`define CONT_REPEAT_CYC (`CONT_REPEAT_NS / `CLK_PERIOD_NS)
`endif

// File: verilog/console_pkg.sv
// types shared by the operator console command logic
package console_pkg;
    typedef enum logic [2:0] {
        cmd_none,
        cmd_hold,
        cmd_stop,
        cmd_estop,
        cmd_resume,
        cmd_clear,
        cmd_store,
        cmd_return
    } command_t;
    typedef struct packed {
        logic [2:0] code;
        logic [17:0] test_no;
        logic valid;
    } test_req_t;
    typedef struct packed {
        logic hold;
        logic stop;
        logic estop;
        logic manual;
    } station_status_t;
    typedef struct packed {
        logic active;
        logic by_operator;
    } cond_ind_t;
endpackage : console_pkg

// File: verilog/operator_logic_unit.sv
// operator console command logic: keyboard, commands, station arbitration, simulator, data requests
`timescale 1ns/1ps
`include "console_defs.svh"

// Functional notes
// - eight octal digit keys feed keyboard register
// - entry key sends keyboard contents out
// - keyboard clear empties the register
// - six-digit readout shows keyboard register
// - readouts show running and next test
// - hold pauses at next hold point
// - stop halts, returns to stop location
// - emergency stop halts at once, shutdown
// - resume restarts after hold or stop
// - clear resets program, drops pending request
// - conditional enables pause at each point
// - store point saves, second press returns
// - master station requests beat external stations
// - indicators show condition and its originator
// - single step: one step per resume
// - simulated interrupt lamp stays, condition appears
// - enabled station enters directly, else operator
// - per-station test number and status readouts
// - 24 switches entered parallel on channel six
// - channel five outputs on lamps, on lamp
// - data requests sent, repeated when continuous
// - four-character display shows returned value
module operator_logic_unit #(
    parameter int REPEAT_CYC = `CONT_REPEAT_CYC
) (
    input wire logic mclk, // clock
    input wire logic rst, // async reset, active high
    input wire logic [7:0] digit_key, // one-hot digit key pulses 0..7
    input wire logic enter_key, // keyboard entry pulse
    input wire logic kbd_clear_key, // keyboard clear pulse
    input wire logic hold_key, // hold pulse
    input wire logic stop_key, // stop pulse
    input wire logic estop_key, // emergency stop pulse
    input wire logic resume_key, // resume pulse
    input wire logic clear_key, // program clear pulse
    input wire logic store_key, // store program point pulse
    input wire logic cond_stop_en, // conditional stops enabled level
    input wire logic cond_hold_en, // conditional holds enabled level
    input wire logic single_step_en, // single step mode level
    input wire logic [17:0] running_test, // running test id from computer
    input wire logic [17:0] next_test, // queued test id from computer
    input wire logic auto_hold, // hold raised by automatic system
    input wire logic auto_stop, // stop raised by automatic system
    input wire logic auto_estop, // emergency stop raised by automatic system
    input wire logic cond_cleared, // computer reports condition released
    input wire logic sim_int_event, // simulated interrupt occurred pulse
    input wire logic sim_int_done, // simulated interrupt processed pulse
    input wire logic [2:0][17:0] stn_test_no, // requested number per station
    input wire logic [2:0] stn_req, // station request pulse
    input wire console_pkg::station_status_t [2:0] stn_status_in, // station status
    input wire logic [2:0] stn_enable, // direct entry enable per station
    input wire logic [2:0] stn_fwd_key, // operator forwards station request
    input wire logic [2:0] stn_wait_key, // operator defers station request
    input wire logic sim_on, // simulator panel switched on
    input wire logic [23:0] sim_switches, // bit switches 23..0 left to right
    input wire logic sim_enter_key, // simulator entry pulse
    input wire logic [23:0] link_ch5_data, // channel five output word
    input wire logic [1:0][11:0] dreq_select, // octal four-digit request numbers
    input wire logic [1:0] dreq_initiate, // request initiate pulses
    input wire logic [1:0] dreq_continuous, // continuous request levels
    input wire logic [1:0] dreq_answer_valid, // answer strobe per set
    input wire logic [1:0][31:0] dreq_answer, // four characters per set
    output logic [17:0] kbd_readout, // keyboard readout
    output logic [17:0] running_readout, // running test readout
    output logic [17:0] next_readout, // next test readout
    output console_pkg::test_req_t test_req, // request to computer link unit
    output console_pkg::command_t command, // command pulse to computer
    output logic step_grant, // one-step permit pulse
    output logic cond_stop_out, // conditional stop mode to computer
    output logic cond_hold_out, // conditional hold mode to computer
    output console_pkg::cond_ind_t hold_ind, // hold indicator
    output console_pkg::cond_ind_t stop_ind, // stop indicator
    output console_pkg::cond_ind_t estop_ind, // emergency stop indicator
    output logic point_stored_ind, // program point stored lamp
    output logic single_step_ind, // single step lamp
    output logic sim_int_ind, // simulated interrupt lamp
    output logic [2:0][17:0] stn_readout, // station number readouts
    output console_pkg::station_status_t [2:0] stn_status_ind, // station lamps
    output logic [2:0] stn_pending_ind, // station request waiting
    output logic sim_word_valid, // simulator word strobe
    output logic [23:0] sim_word, // simulator word
    output logic [2:0] sim_channel, // channel of simulator word
    output logic [23:0] ch5_lamps, // channel five lamps
    output logic sim_on_ind, // simulator active lamp
    output logic [1:0] dreq_valid, // data request strobe per set
    output logic [1:0][11:0] dreq_number, // data request number per set
    output logic [1:0][31:0] data_value_disp // data value displays
);
    logic [17:0] kbd_q, kbd_d;
    console_pkg::test_req_t req_q, req_d;
    console_pkg::command_t cmd_q, cmd_d;
    logic step_q, step_d;
    console_pkg::cond_ind_t hold_q, hold_d, stop_q, stop_d, estop_q, estop_d;
    logic stored_q, stored_d;
    logic sim_int_q, sim_int_d;
    logic [2:0] pend_q, pend_d;
    logic [2:0][17:0] stn_rd_q, stn_rd_d;
    console_pkg::station_status_t [2:0] stn_st_q, stn_st_d;
    logic [17:0] run_q, run_d, nxt_q, nxt_d;
    logic simv_q, simv_d;
    logic [23:0] simw_q, simw_d, ch5_q, ch5_d;
    logic master_req;
    logic [2:0] stn_ready;
    int sel;

    assign master_req = enter_key | clear_key;

    always_comb begin
        kbd_d = kbd_q;
        for (int i = 0; i < 8; i++) begin
            if (digit_key[i]) begin
                kbd_d = {kbd_q[14:0], 3'(i)};
            end
        end
        if (kbd_clear_key) begin
            kbd_d = '0;
        end
    end

    always_comb begin
        pend_d = pend_q;
        stn_rd_d = stn_rd_q;
        stn_st_d = stn_status_in;
        stn_ready = '0;
        sel = -1;
        for (int s = 0; s < `NUM_STATIONS; s++) begin
            if (stn_req[s]) begin
                pend_d[s] = 1'b1;
                stn_rd_d[s] = stn_test_no[s];
            end
            stn_ready[s] = pend_q[s] & (stn_enable[s] | stn_fwd_key[s]);
            if (stn_wait_key[s]) begin
                stn_ready[s] = 1'b0;
            end
        end
        for (int s = `NUM_STATIONS - 1; s >= 0; s--) begin
            if (stn_ready[s]) begin
                sel = s;
            end
        end
        req_d = '0;
        if (enter_key) begin
            req_d = '{code: 3'h0, test_no: kbd_q, valid: 1'b1};
        end else if (!master_req && sel >= 0) begin
            req_d = '{code: 3'(sel + 1), test_no: stn_rd_q[sel], valid: 1'b1};
            pend_d[sel] = stn_req[sel];
        end
        if (clear_key) begin
            pend_d = '0;
        end
    end

    always_comb begin
        cmd_d = console_pkg::cmd_none;
        step_d = 1'b0;
        hold_d = hold_q;
        stop_d = stop_q;
        estop_d = estop_q;
        stored_d = stored_q;
        sim_int_d = sim_int_q;
        if (estop_key) begin
            cmd_d = console_pkg::cmd_estop;
        end else if (clear_key) begin
            cmd_d = console_pkg::cmd_clear;
        end else if (stop_key) begin
            cmd_d = console_pkg::cmd_stop;
        end else if (hold_key) begin
            cmd_d = console_pkg::cmd_hold;
        end else if (store_key) begin
            cmd_d = stored_q ? console_pkg::cmd_return : console_pkg::cmd_store;
            stored_d = !stored_q;
        end else if (resume_key) begin
            cmd_d = console_pkg::cmd_resume;
            step_d = single_step_en;
        end
        if (cond_cleared || clear_key) begin
            hold_d = '0;
            stop_d = '0;
            estop_d = '0;
        end
        // set wins over the clear so no condition is lost
        if (hold_key || auto_hold) begin
            hold_d = '{active: 1'b1, by_operator: hold_key};
        end
        if (stop_key || auto_stop) begin
            stop_d = '{active: 1'b1, by_operator: stop_key};
        end
        if (estop_key || auto_estop) begin
            estop_d = '{active: 1'b1, by_operator: estop_key};
        end
        if (clear_key) begin
            stored_d = 1'b0;
        end
        if (sim_int_done && !hold_d.active && !stop_d.active && !estop_d.active) begin
            hold_d = '{active: 1'b1, by_operator: 1'b0};
        end
        if (sim_int_event) begin
            sim_int_d = 1'b1;
        end else if (clear_key) begin
            sim_int_d = 1'b0;
        end
    end

    always_comb begin
        run_d = running_test;
        nxt_d = next_test;
        simv_d = sim_on & sim_enter_key;
        simw_d = simv_d ? sim_switches : simw_q;
        ch5_d = sim_on ? link_ch5_data : '0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            kbd_q <= '0;
            req_q <= '0;
            cmd_q <= console_pkg::cmd_none;
            step_q <= 1'b0;
            hold_q <= '0;
            stop_q <= '0;
            estop_q <= '0;
            stored_q <= 1'b0;
            sim_int_q <= 1'b0;
            pend_q <= '0;
            stn_rd_q <= '0;
            stn_st_q <= '0;
            run_q <= '0;
            nxt_q <= '0;
            simv_q <= 1'b0;
            simw_q <= '0;
            ch5_q <= '0;
        end else begin
            kbd_q <= kbd_d;
            req_q <= req_d;
            cmd_q <= cmd_d;
            step_q <= step_d;
            hold_q <= hold_d;
            stop_q <= stop_d;
            estop_q <= estop_d;
            stored_q <= stored_d;
            sim_int_q <= sim_int_d;
            pend_q <= pend_d;
            stn_rd_q <= stn_rd_d;
            stn_st_q <= stn_st_d;
            run_q <= run_d;
            nxt_q <= nxt_d;
            simv_q <= simv_d;
            simw_q <= simw_d;
            ch5_q <= ch5_d;
        end
    end

    // data request sets; the repeat period spaces continuous repeats, while an initiate pulse loads the link at once
    for (genvar g = 0; g < 2; g++) begin : g_dreq
        logic [31:0] cnt_q, cnt_d;
        logic v_q, v_d;
        logic [11:0] n_q, n_d;
        logic [31:0] val_q, val_d;
        always_comb begin
            cnt_d = cnt_q;
            v_d = 1'b0;
            n_d = n_q;
            val_d = dreq_answer_valid[g] ? dreq_answer[g] : val_q;
            if (dreq_initiate[g]) begin
                v_d = 1'b1;
                n_d = dreq_select[g];
                cnt_d = 32'(REPEAT_CYC - 1);
            end else if (dreq_continuous[g]) begin
                if (cnt_q == 32'h0) begin
                    v_d = 1'b1;
                    n_d = dreq_select[g];
                    cnt_d = 32'(REPEAT_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 32'h1;
                end
            end
        end
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cnt_q <= '0;
                v_q <= 1'b0;
                n_q <= '0;
                val_q <= '0;
            end else begin
                cnt_q <= cnt_d;
                v_q <= v_d;
                n_q <= n_d;
                val_q <= val_d;
            end
        end
        assign dreq_valid[g] = v_q;
        assign dreq_number[g] = n_q;
        assign data_value_disp[g] = val_q;
    end

    assign kbd_readout = kbd_q;
    assign running_readout = run_q;
    assign next_readout = nxt_q;
    assign test_req = req_q;
    assign command = cmd_q;
    assign step_grant = step_q;
    assign cond_stop_out = cond_stop_en;
    assign cond_hold_out = cond_hold_en;
    assign hold_ind = hold_q;
    assign stop_ind = stop_q;
    assign estop_ind = estop_q;
    assign point_stored_ind = stored_q;
    assign single_step_ind = single_step_en;
    assign sim_int_ind = sim_int_q;
    assign stn_readout = stn_rd_q;
    assign stn_status_ind = stn_st_q;
    assign stn_pending_ind = pend_q;
    assign sim_word_valid = simv_q;
    assign sim_word = simw_q;
    assign sim_channel = `SIM_IN_CHANNEL;
    assign ch5_lamps = ch5_q;
    assign sim_on_ind = sim_on;

    a_kbd_shift: assert property (@(posedge mclk) disable iff (rst)
        (digit_key == 8'h08 && !kbd_clear_key) |=> kbd_readout == {$past(kbd_readout[14:0]), 3'h3})
        else $error("digit not shifted in");
    a_kbd_clear: assert property (@(posedge mclk) disable iff (rst)
        kbd_clear_key |=> kbd_readout == 18'h0) else $error("keyboard not cleared");
    a_enter_sends: assert property (@(posedge mclk) disable iff (rst)
        enter_key |=> test_req.valid && test_req.code == 3'h0 && test_req.test_no == $past(kbd_q))
        else $error("entry not sent");
    a_master_first: assert property (@(posedge mclk) disable iff (rst)
        (enter_key && |pend_q) |=> test_req.code == 3'h0) else $error("station beat master");
    a_estop_first: assert property (@(posedge mclk) disable iff (rst)
        estop_key |=> command == console_pkg::cmd_estop && estop_ind == 2'b11)
        else $error("estop not immediate");
    a_clear_drops: assert property (@(posedge mclk) disable iff (rst)
        clear_key |=> stn_pending_ind == 3'h0 && !test_req.valid) else $error("request kept");
    a_step_once: assert property (@(posedge mclk) disable iff (rst)
        (step_grant && !resume_key) |=> !step_grant) else $error("more than one step");
    a_store_toggle: assert property (@(posedge mclk) disable iff (rst)
        (command == console_pkg::cmd_store) |-> point_stored_ind) else $error("store lost");
    a_sim_lamp: assert property (@(posedge mclk) disable iff (rst)
        sim_int_event ##1 (!clear_key) [*2] |-> sim_int_ind) else $error("sim lamp dropped");
    a_sim_word: assert property (@(posedge mclk) disable iff (rst)
        (sim_on && sim_enter_key) |=> sim_word_valid && sim_word == $past(sim_switches))
        else $error("sim word wrong");
    a_auto_hold: assert property (@(posedge mclk) disable iff (rst)
        (auto_hold && !hold_key) |=> hold_ind == 2'b10) else $error("hold origin wrong");
    c_station_direct: cover property (@(posedge mclk) disable iff (rst)
        test_req.valid && test_req.code != 3'h0);
    c_continuous: cover property (@(posedge mclk) disable iff (rst)
        dreq_valid[0] ##[1:200] dreq_valid[0]);
    c_store_return: cover property (@(posedge mclk) disable iff (rst)
        command == console_pkg::cmd_return);
    c_single_step: cover property (@(posedge mclk) disable iff (rst) step_grant);
endmodule : operator_logic_unit
